//--- pal_pkg.sv
package pal_pkg;
  // ==========================================================
  // widths
  localparam int PAL_DW = 16;
  localparam int PAL_FRAC = 8;
  localparam int PAL_DIO_N = 4;
  localparam int PAL_NPIN = 3 + PAL_DIO_N;
  localparam int PAL_PIN_ADV = 0;
  localparam int PAL_PIN_RST = 1;
  localparam int PAL_PIN_FK = 2;
  localparam int PAL_PIN_DIO0 = 3;
  // ==========================================================
  // register word indices, byte address is four times the index
  localparam logic [5:0] IX_CTRL = 6'h00;
  localparam logic [5:0] IX_ALM_LO = 6'h01;
  localparam logic [5:0] IX_ALM_HI = 6'h02;
  localparam logic [5:0] IX_HYST = 6'h03;
  localparam logic [5:0] IX_IN_SLO = 6'h04;
  localparam logic [5:0] IX_IN_SHI = 6'h05;
  localparam logic [5:0] IX_IN_RLO = 6'h06;
  localparam logic [5:0] IX_IN_RHI = 6'h07;
  localparam logic [5:0] IX_RTX_SLO = 6'h08;
  localparam logic [5:0] IX_RTX_SHI = 6'h09;
  localparam logic [5:0] IX_RTX_RLO = 6'h0a;
  localparam logic [5:0] IX_RTX_RHI = 6'h0b;
  localparam logic [5:0] IX_LIM_LO = 6'h0c;
  localparam logic [5:0] IX_LIM_HI = 6'h0d;
  localparam logic [5:0] IX_CLR_LIM = 6'h0f;
  localparam logic [5:0] IX_STATUS = 6'h10;
  localparam logic [5:0] IX_PV = 6'h11;
  localparam logic [5:0] IX_RTX = 6'h12;
  localparam logic [5:0] IX_VAL_LAST = IX_LIM_HI;
  localparam logic [31:0] PAL_CLR_LIM_CODE = 32'h0000_0000;
  // ==========================================================
  // modes
  typedef enum logic [1:0] {ATYPE_BOTH, ATYPE_HIGH, ATYPE_LOW, ATYPE_RSV} pal_atype_e;
  typedef enum logic [1:0] {RESP_NONE, RESP_CLEAR, RESP_SILENCE, RESP_RSV} pal_resp_e;
  typedef enum logic [1:0] {SRC_PV, SRC_ALM_LO, SRC_ALM_HI, SRC_RAW} pal_src_e;
  typedef enum logic {LIM_SAFE, LIM_TRIPPED} pal_lim_e;
  // ==========================================================
  // control word layout
  typedef struct packed {
    logic [13:0] rsv;
    logic [3:0] dio_inst;
    logic lim_fkey;
    logic [3:0] filt_shift;
    pal_resp_e resp;
    pal_src_e rtx_src;
    pal_atype_e atype;
    logic block_en;
    logic silence_en;
    logic latch_en;
  } pal_ctrl_s;
  // ==========================================================
  // whole block state
  typedef struct packed {
    pal_ctrl_s ctrl;
    logic [14:1][PAL_DW-1:0] vals;
    logic signed [PAL_DW+PAL_FRAC-1:0] filt;
    logic signed [PAL_DW-1:0] pv;
    logic signed [PAL_DW-1:0] rtx;
    logic [31:0] rdata;
    logic alarm;
    logic silenced;
    logic blocked;
    logic pend_clear;
    logic pend_sil;
    pal_lim_e lim;
    logic [PAL_NPIN-1:0] s1;
    logic [PAL_NPIN-1:0] s2;
    logic [PAL_NPIN-1:0] s3;
    logic [PAL_NPIN-1:0] lvl;
  } pal_state_s;
endpackage

//--- pal_alarm_limit.sv
`timescale 1ns/10ps
`default_nettype none
module pal_alarm_limit
  import pal_pkg::*;
#(
  parameter logic signed [PAL_DW-1:0] HW_MIN = 16'sh8000,
  parameter logic signed [PAL_DW-1:0] HW_MAX = 16'sh7fff
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic signed [PAL_DW-1:0] i_sample,
  input wire logic i_sample_valid,
  input wire logic i_key_advance,
  input wire logic i_key_reset,
  input wire logic i_func_key,
  input wire logic [PAL_DIO_N-1:0] i_dio,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [31:0] o_rdata,
  output logic o_alarm_state,
  output logic o_alarm_out,
  output logic o_relay_coil,
  output logic signed [PAL_DW-1:0] o_rtx,
  output logic signed [PAL_DW-1:0] o_pv
);
  // ==========================================================
  // linear map with saturation to the output end points
  function automatic logic signed [PAL_DW-1:0] lin_map(
    input logic signed [PAL_DW-1:0] x,
    input logic signed [PAL_DW-1:0] x0,
    input logic signed [PAL_DW-1:0] x1,
    input logic signed [PAL_DW-1:0] y0,
    input logic signed [PAL_DW-1:0] y1);
    logic signed [PAL_DW:0] dx;
    logic signed [PAL_DW:0] dy;
    logic signed [PAL_DW:0] den;
    logic signed [2*PAL_DW+1:0] num;
    logic signed [2*PAL_DW+1:0] r;
    logic signed [2*PAL_DW+1:0] lo;
    logic signed [2*PAL_DW+1:0] hi;
    dx = (PAL_DW+1)'(x) - (PAL_DW+1)'(x0);
    dy = (PAL_DW+1)'(y1) - (PAL_DW+1)'(y0);
    den = (PAL_DW+1)'(x1) - (PAL_DW+1)'(x0);
    num = (2*PAL_DW+2)'(dx) * (2*PAL_DW+2)'(dy);
    lo = (y0 < y1) ? (2*PAL_DW+2)'(y0) : (2*PAL_DW+2)'(y1);
    hi = (y0 < y1) ? (2*PAL_DW+2)'(y1) : (2*PAL_DW+2)'(y0);
    // a zero-width input range would divide by zero, so it pins to y0
    if (den == '0) begin
      r = (2*PAL_DW+2)'(y0);
    end else begin
      r = (2*PAL_DW+2)'(y0) + num / (2*PAL_DW+2)'(den);
    end
    if (r < lo) begin
      r = lo;
    end
    if (r > hi) begin
      r = hi;
    end
    return PAL_DW'(r);
  endfunction

  // ==========================================================
  // state and working signals
  pal_state_s q;
  pal_state_s d;
  logic [PAL_NPIN-1:0] pins;
  logic [PAL_NPIN-1:0] lvl_new;
  logic [PAL_NPIN-1:0] press;
  logic [5:0] idx;
  logic signed [PAL_DW-1:0] x_clamp;
  logic signed [PAL_DW+PAL_FRAC:0] f_diff;
  logic signed [PAL_DW+PAL_FRAC:0] f_step;
  logic signed [PAL_DW-1:0] f_out;
  logic signed [PAL_DW-1:0] sp_lo;
  logic signed [PAL_DW-1:0] sp_hi;
  logic signed [PAL_DW:0] clr_lo;
  logic signed [PAL_DW:0] clr_hi;
  logic hi_en;
  logic lo_en;
  logic hi_cond;
  logic lo_cond;
  logic cond;
  logic normal;
  logic gate;
  logic key_any;
  logic lim_cause;
  logic lim_rst;
  logic fb_clr;
  logic dio_ok;
  logic signed [PAL_DW-1:0] rtx_src_val;

  assign pins = {i_dio, i_func_key, i_key_reset, i_key_advance};
  assign idx = i_addr[7:2];

  // ==========================================================
  // key and input debouncing: a change counts once stages two and three agree
  assign lvl_new = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
  assign press = lvl_new & ~q.lvl;
  assign key_any = press[PAL_PIN_ADV] | press[PAL_PIN_RST];

  // ==========================================================
  // input path: clamp, filter, scale
  always_comb begin
    x_clamp = i_sample;
    if (i_sample < HW_MIN) begin
      x_clamp = HW_MIN;
    end
    if (i_sample > HW_MAX) begin
      x_clamp = HW_MAX;
    end
  end
  // shift-based filter: time constant is 2^filt_shift samples, no multiplier needed
  assign f_diff = (PAL_DW+PAL_FRAC+1)'(signed'({x_clamp, {PAL_FRAC{1'b0}}})) - (PAL_DW+PAL_FRAC+1)'(q.filt);
  assign f_step = f_diff >>> q.ctrl.filt_shift;
  assign f_out = PAL_DW'(q.filt >>> PAL_FRAC);

  // ==========================================================
  // alarm thresholds
  assign sp_lo = q.vals[IX_ALM_LO[3:0]];
  assign sp_hi = q.vals[IX_ALM_HI[3:0]];
  assign clr_lo = (PAL_DW+1)'(sp_lo) + (PAL_DW+1)'(signed'(q.vals[IX_HYST[3:0]]));
  assign clr_hi = (PAL_DW+1)'(sp_hi) - (PAL_DW+1)'(signed'(q.vals[IX_HYST[3:0]]));
  // a reserved type code behaves as two set points
  assign hi_en = q.ctrl.atype != ATYPE_LOW;
  assign lo_en = q.ctrl.atype != ATYPE_HIGH;
  assign hi_cond = hi_en && (q.pv >= sp_hi);
  assign lo_cond = lo_en && (q.pv <= sp_lo);
  assign cond = hi_cond | lo_cond;
  assign normal = (!hi_en || ((PAL_DW+1)'(q.pv) < clr_hi)) && (!lo_en || ((PAL_DW+1)'(q.pv) > clr_lo));
  assign gate = cond && !(q.ctrl.block_en && q.blocked);

  // ==========================================================
  // limit trip and reset sources
  assign lim_cause = (q.pv >= signed'(q.vals[IX_LIM_HI[3:0]])) || (q.pv <= signed'(q.vals[IX_LIM_LO[3:0]]));
  assign fb_clr = i_we && (idx == IX_CLR_LIM) && (i_wdata == PAL_CLR_LIM_CODE);
  assign dio_ok = q.ctrl.dio_inst < 4'(PAL_DIO_N);
  always_comb begin
    lim_rst = fb_clr;
    if (q.ctrl.lim_fkey) begin
      lim_rst = lim_rst | press[PAL_PIN_FK];
    end else if (dio_ok) begin
      lim_rst = lim_rst | press[PAL_PIN_DIO0 + int'(q.ctrl.dio_inst)];
    end
  end

  // ==========================================================
  // retransmit source
  always_comb begin
    unique case (q.ctrl.rtx_src)
      SRC_PV: rtx_src_val = q.pv;
      SRC_ALM_LO: rtx_src_val = sp_lo;
      SRC_ALM_HI: rtx_src_val = sp_hi;
      SRC_RAW: rtx_src_val = f_out;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = lvl_new;
    // filter and scaling
    if (i_sample_valid) begin
      d.filt = q.filt + (PAL_DW+PAL_FRAC)'(f_step);
    end
    d.pv = lin_map(f_out, q.vals[IX_IN_SLO[3:0]], q.vals[IX_IN_SHI[3:0]],
                   q.vals[IX_IN_RLO[3:0]], q.vals[IX_IN_RHI[3:0]]);
    d.rtx = lin_map(rtx_src_val, q.vals[IX_RTX_RLO[3:0]], q.vals[IX_RTX_RHI[3:0]],
                    q.vals[IX_RTX_SLO[3:0]], q.vals[IX_RTX_SHI[3:0]]);
    // operator response is captured at the press and applied one edge later
    d.pend_clear = key_any && (q.ctrl.resp == RESP_CLEAR);
    d.pend_sil = key_any && (q.ctrl.resp == RESP_SILENCE);
    // blocking ends the first time the value is normal
    d.blocked = q.blocked && !normal;
    // alarm state, evaluated with or without an output attached; a new trip wins over a clear
    if (gate) begin
      d.alarm = 1'b1;
    end else if (q.ctrl.latch_en) begin
      d.alarm = q.alarm && !(q.pend_clear && normal);
    end else begin
      d.alarm = q.alarm && !normal;
    end
    // silence holds until the value is back normal
    d.silenced = (q.pend_sil && q.ctrl.silence_en && q.alarm) || (q.silenced && !normal);
    // limit relay: a live cause overrides any reset
    unique case (q.lim)
      LIM_SAFE: begin
        if (lim_cause) begin
          d.lim = LIM_TRIPPED;
        end
      end
      LIM_TRIPPED: begin
        if (!lim_cause && lim_rst) begin
          d.lim = LIM_SAFE;
        end
      end
    endcase
    // register writes
    if (i_we) begin
      if (idx == IX_CTRL) begin
        d.ctrl = pal_ctrl_s'(i_wdata);
        d.ctrl.rsv = '0;
      end else if ((idx >= IX_ALM_LO) && (idx <= IX_VAL_LAST)) begin
        d.vals[idx[3:0]] = i_wdata[PAL_DW-1:0];
      end
    end
    // read data stands one cycle after the strobe only
    d.rdata = '0;
    if (i_re) begin
      unique case (idx)
        IX_CTRL: d.rdata = q.ctrl;
        IX_STATUS: d.rdata = {26'h0, lim_cause, q.lim == LIM_TRIPPED, q.blocked, q.silenced, q.alarm, cond};
        IX_PV: d.rdata = {16'h0, q.pv};
        IX_RTX: d.rdata = {16'h0, q.rtx};
        default: begin
          if ((idx >= IX_ALM_LO) && (idx <= IX_VAL_LAST)) begin
            d.rdata = {16'h0, q.vals[idx[3:0]]};
          end
        end
      endcase
    end
  end

  // ==========================================================
  // state register; limit starts safe and trips at once if the cause is live
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
      q.blocked <= 1'b1;
      q.ctrl.block_en <= 1'b1; // all-zero set points would otherwise alarm at the first edge
      q.lim <= LIM_SAFE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata = q.rdata;
  assign o_alarm_state = q.alarm;
  assign o_alarm_out = q.alarm && !q.silenced;
  assign o_relay_coil = q.lim == LIM_SAFE;
  assign o_rtx = q.rtx;
  assign o_pv = q.pv;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_clear_ready;
    q.pend_clear && q.ctrl.latch_en && q.alarm && normal && !gate;
  endsequence
  sequence s_key_clear;
    key_any && (q.ctrl.resp == RESP_CLEAR);
  endsequence

  a_alarm_entry: assert property (gate |=> o_alarm_state)
    else $error("alarm did not set on set point");
  a_hyst_hold: assert property (q.alarm && !normal |=> q.alarm)
    else $error("alarm cleared inside hysteresis");
  a_latch_hold: assert property (q.ctrl.latch_en && q.alarm && !q.pend_clear |=> q.alarm)
    else $error("latched alarm dropped without clear");
  a_self_clear: assert property (!q.ctrl.latch_en && q.alarm && normal && !gate |=> !q.alarm)
    else $error("unlatched alarm stayed on");
  a_silence_mute: assert property (q.pend_sil && q.ctrl.silence_en && q.alarm && !normal
    |=> !o_alarm_out && o_alarm_state)
    else $error("silence did not mute output");
  a_silence_rearm: assert property (q.silenced && normal && !q.pend_sil |=> !q.silenced)
    else $error("silence not re-armed");
  a_clear_apply: assert property (s_key_clear ##1 s_clear_ready |=> !o_alarm_state)
    else $error("clear request not applied");
  a_req_capture: assert property (s_key_clear |=> q.pend_clear ##1 !q.pend_clear || $past(key_any))
    else $error("clear request not registered");
  a_coil_safe: assert property (o_relay_coil && !lim_cause |=> o_relay_coil)
    else $error("coil off in safe state");
  a_trip_open: assert property (lim_cause |=> !o_relay_coil)
    else $error("limit did not trip");
  a_trip_latched: assert property (!o_relay_coil && !lim_rst |=> !o_relay_coil)
    else $error("relay closed without reset");
  a_bus_clear: assert property (fb_clr && !lim_cause && !o_relay_coil |=> o_relay_coil)
    else $error("fieldbus clear ignored");
  a_rtx_low_end: assert property ((rtx_src_val == signed'(q.vals[IX_RTX_RLO[3:0]]))
    && (q.vals[IX_RTX_RLO[3:0]] != q.vals[IX_RTX_RHI[3:0]])
    |=> o_rtx == signed'($past(q.vals[IX_RTX_SLO[3:0]])))
    else $error("retransmit low end wrong");
  a_block_start: assert property (q.ctrl.block_en && q.blocked && !q.alarm |=> !q.alarm)
    else $error("alarm raised while blocked");
endmodule
`default_nettype wire

//--- pal_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// operator panel and digital inputs: holds the asked-for pins high for
// six cycles, long enough to pass the three-stage synchroniser twice over
module pal_panel_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [6:0] i_pins,
  output logic [6:0] o_pins
);
  logic [6:0] pins_q = 7'h00;
  logic [2:0] hold_q = 3'h0;
  assign o_pins = pins_q;
  // a press is one level pulse; the device acts on its rising edge only
  always @(posedge i_clk) begin
    if (i_req) begin
      pins_q <= i_pins;
      hold_q <= 3'h6;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
      if (hold_q == 3'h1) begin
        pins_q <= 7'h00;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_process_alarm_limit_logic.sv
`timescale 1ns/10ps
`default_nettype none
module tb_process_alarm_limit_logic;
  import pal_pkg::*;
  logic i_clk = 1'b0, i_reset = 1'b1, i_sample_valid = 1'b0, i_we = 1'b0, i_re = 1'b0, req = 1'b0;
  logic signed [PAL_DW-1:0] i_sample = 16'sh0000;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, tbl [1:13];
  logic [6:0] pins, req_pins = 7'h00;
  logic o_alarm_state, o_alarm_out, o_relay_coil;
  logic signed [PAL_DW-1:0] o_rtx, o_pv;
  pal_ctrl_s c;
  int miscompares = 0, cmp_count = 0, x;
  pal_alarm_limit #(.HW_MIN(16'shf448), .HW_MAX(16'sh0bb8)) i_pal_alarm_limit (.i_clk(i_clk),
    .i_reset(i_reset), .i_sample(i_sample), .i_sample_valid(i_sample_valid), .i_key_advance(pins[0]),
    .i_key_reset(pins[1]), .i_func_key(pins[2]), .i_dio(pins[6:3]), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .o_alarm_state(o_alarm_state), .o_alarm_out(o_alarm_out),
    .o_relay_coil(o_relay_coil), .o_rtx(o_rtx), .o_pv(o_pv));
  pal_panel_model i_pal_panel_model (.i_clk(i_clk), .i_req(req), .i_pins(req_pins), .o_pins(pins));
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  // ==========================================================
  // helpers
  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  // linear map with truncating division and saturation to the output ends
  function automatic logic [31:0] lin(input int v, input int x0, input int x1, input int y0, input int y1);
    int y;
    y = (x1 == x0) ? y0 : y0 + (v - x0) * (y1 - y0) / (x1 - x0);
    if (y < ((y0 < y1) ? y0 : y1)) y = (y0 < y1) ? y0 : y1;
    if (y > ((y0 < y1) ? y1 : y0)) y = (y0 < y1) ? y1 : y0;
    return {16'h0000, y[15:0]};
  endfunction
  task automatic wr(input logic [5:0] ix, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= {ix, 2'b00};
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] ix, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= {ix, 2'b00};
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1 d = o_rdata;
  endtask
  // sample in, then wait past the alarm and retransmit update edges
  task automatic smp(input int v);
    @(posedge i_clk);
    i_sample <= v[15:0];
    i_sample_valid <= 1'b1;
    @(posedge i_clk);
    i_sample_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic press(input logic [6:0] p);
    @(posedge i_clk);
    req <= 1'b1;
    req_pins <= p;
    @(posedge i_clk);
    req <= 1'b0;
    repeat (14) @(posedge i_clk);
    #1;
  endtask
  task automatic alm(input logic s, input logic o);
    chk("alarm_state", {31'h0, s}, {31'h0, o_alarm_state});
    chk("alarm_out", {31'h0, o}, {31'h0, o_alarm_out});
  endtask
  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] d;
    void'($urandom(1013));
    c = '0;
    // input scaling is the identity over -4000..4000, so the clamp and both limit ends are reachable
    tbl = '{32'd200, 32'd800, 32'd100, 32'h0000f060, 32'd4000, 32'h0000f060, 32'd4000, 32'd100, 32'd0, 32'd0,
      32'd1000, 32'h0000fc18, 32'd2000};
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    #1 chk("coil_in_reset", 32'h1, {31'h0, o_relay_coil});
    c.block_en = 1'b1;
    wr(IX_CTRL, 32'(c));
    for (int i = 1; i <= 13; i++) wr(i[5:0], tbl[i]);
    wr(IX_CLR_LIM, PAL_CLR_LIM_CODE);
    smp(0);
    chk("coil_cleared", 32'h1, {31'h0, o_relay_coil});
    alm(1'b0, 1'b0);
    smp(800);
    alm(1'b0, 1'b0);
    smp(500);
    smp(800);
    alm(1'b1, 1'b1);
    smp(700);
    alm(1'b1, 1'b1);
    smp(699);
    alm(1'b0, 1'b0);
    // one-sided and two-sided alarm types; the reserved code acts as two set points
    for (int t = 0; t < 4; t++) begin
      c.atype = pal_atype_e'(t);
      wr(IX_CTRL, 32'(c));
      smp(800);
      chk("type_high", {31'h0, t != 2}, {31'h0, o_alarm_state});
      smp(500);
      smp(200);
      chk("type_low", {31'h0, t != 1}, {31'h0, o_alarm_state});
      smp(500);
    end
    c.atype = ATYPE_BOTH;
    c.latch_en = 1'b1;
    c.resp = RESP_CLEAR;
    wr(IX_CTRL, 32'(c));
    smp(800);
    smp(500);
    alm(1'b1, 1'b1);
    press(7'h01);
    alm(1'b0, 1'b0);
    c.silence_en = 1'b1;
    c.resp = RESP_SILENCE;
    wr(IX_CTRL, 32'(c));
    smp(800);
    press(7'h02);
    alm(1'b1, 1'b0);
    smp(500);
    alm(1'b1, 1'b1);
    c.resp = RESP_CLEAR;
    c.lim_fkey = 1'b1;
    wr(IX_CTRL, 32'(c));
    press(7'h01);
    alm(1'b0, 1'b0);
    // limit trip, clamp, latch-open and both reset sources
    smp(4000);
    chk("pv_clamp", 32'd3000, {16'h0, o_pv});
    chk("coil_trip", 32'h0, {31'h0, o_relay_coil});
    chk("rtx_sat", 32'h0, {16'h0, o_rtx});
    smp(500);
    wr(IX_CLR_LIM, 32'h1);
    repeat (2) @(posedge i_clk);
    #1 chk("coil_held", 32'h0, {31'h0, o_relay_coil});
    press(7'h04);
    chk("coil_fkey", 32'h1, {31'h0, o_relay_coil});
    c.lim_fkey = 1'b0;
    c.dio_inst = 4'h2;
    wr(IX_CTRL, 32'(c));
    smp(-1000);
    chk("coil_trip_low", 32'h0, {31'h0, o_relay_coil});
    smp(500);
    press(7'h08);
    chk("coil_wrong_dio", 32'h0, {31'h0, o_relay_coil});
    press(7'h20);
    chk("coil_dio", 32'h1, {31'h0, o_relay_coil});
    press(7'h01);
    c.filt_shift = 4'h1;
    wr(IX_CTRL, 32'(c));
    smp(1000);
    chk("pv_filter", 32'd750, {16'h0, o_pv});
    c.filt_shift = 4'h0;
    wr(IX_CTRL, 32'(c));
    // range ends first, then random interior points
    for (int k = 0; k < 24; k++) begin
      x = (k == 0) ? 0 : (k == 1) ? 1000 : $urandom_range(1000, 0);
      smp(x);
      chk("pv", lin(x, -4000, 4000, -4000, 4000), {16'h0, o_pv});
      chk("rtx", lin(x, 0, 1000, 100, 0), {16'h0, o_rtx});
    end
    rd(IX_PV, d);
    chk("pv_reg", lin(x, -4000, 4000, -4000, 4000), d);
    rd(6'h14, d);
    chk("unmapped", 32'h0, d);
    for (int s = 1; s < 4; s++) begin
      c.rtx_src = pal_src_e'(s);
      wr(IX_CTRL, 32'(c));
      repeat (3) @(posedge i_clk);
      #1 chk("rtx_src", lin((s == 1) ? 200 : (s == 2) ? 800 : x, 0, 1000, 100, 0), {16'h0, o_rtx});
    end
    complete_run();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
